// file: dv/sarc_link_assertions.sv
// Protocol checks on the link between host and converter device
module sarc_link_assertions
  import sarc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_chain_sel,
  input wire logic convert_strobe,
  input wire logic sck,
  input wire logic output_enable_or_daisy_input,
  input wire logic busy,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [CNT_W-1:0] busy_cnt_ff;

  // Length of the current busy run; cleared whenever busy is low
  always_ff @(posedge i_core_clk) begin
    busy_cnt_ff <= (i_reset || !busy) ? '0 : busy_cnt_ff + 16'h0001;
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  a_busy_follows_start: assert property ($rose(convert_strobe) |-> ##[2:4] $rose(busy))
    else $error("busy did not follow the strobe edge");
  a_busy_run_length: assert property ($fell(busy) |-> busy_cnt_ff == CONV_CYC)
    else $error("busy run length wrong");
  a_busy_no_restart: assert property ($rose(busy) |-> busy [*8])
    else $error("conversion cut short after start");
  a_strobe_late_fall: assert property ($fell(convert_strobe) |-> !busy)
    else $error("strobe moved during conversion");
  a_data_floats_off: assert property (!i_chain_sel && output_enable_or_daisy_input
    |-> !sdo_oe)
    else $error("data driven while disabled");
  a_chain_always_on: assert property (i_chain_sel && $past(i_chain_sel, 8) |-> sdo_oe)
    else $error("data driver off in chain mode");
  a_data_driven_on: assert property (!output_enable_or_daisy_input |-> sdo_oe)
    else $error("data not driven while enabled");
  // Sampling on the core clock sees the serial edge and its data change together
  // A new MSB may appear at busy fall without any serial edge
  a_shift_on_rise: assert property ($changed(sdo) && sdo_oe && $stable(sdo_oe)
    && !$fell(busy) |-> $rose(sck))
    else $error("data changed without a rising serial clock");
  a_clock_quiet_busy: assert property (busy |-> $stable(sck))
    else $error("serial clock ran during conversion");
  a_enable_idle_busy: assert property (busy |-> output_enable_or_daisy_input)
    else $error("output enabled during conversion");

  // Main scenarios reached
  cover property ($rose(convert_strobe));
  cover property ($fell(busy));
  cover property (!output_enable_or_daisy_input ##1 $rose(sck));
endmodule

// file: dv/test_sar_adc_convert_readout.sv
// Self-checking bench: host and converter device joined over the link
module test_sar_adc_convert_readout;
  import sarc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // Short power-on wait keeps the run brief; equal on both ends
  localparam logic [CNT_W-1:0] POR_SIM = 16'h0028;
  localparam int TMO = 20_000;
  localparam logic [RES_BITS-1:0] EDGES [4] = '{20'h0_0000, 20'hF_FFFF, 20'h8_0000, 20'h5_5555};

  logic                i_core_clk;
  logic                i_reset;
  logic                i_start;
  logic                i_supply_low;
  logic [RES_BITS-1:0] i_analog_code;
  logic                o_idle, o_word_valid, o_powered, o_acquiring, o_ready;
  logic                o_conv_done, acq_d, busy_d;
  logic                o_start_ignored, ign_seen, i_chain_sel;
  logic [RES_BITS-1:0] o_word, o_result;
  logic [CNT_W-1:0]    acq_cnt;
  logic [RES_BITS-1:0] exp_q [$];
  logic [RES_BITS-1:0] res_q [$];
  int                  err_total, checked, cyc, n;
  int                  seed = 32'h9768;

  sarc_if link ();

  sarc_device #(.POR_WAIT(POR_SIM)) u_sarc_device (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_supply_low(i_supply_low),
    .i_chain_sel(i_chain_sel), .i_analog_code(i_analog_code), .o_powered(o_powered),
    .o_acquiring(o_acquiring), .o_ready(o_ready), .o_result(o_result),
    .o_conv_done(o_conv_done), .o_start_ignored(o_start_ignored), .link(link)
  );

  sarc_host #(.POR_WAIT(POR_SIM)) u_sarc_host (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_start(i_start), .o_idle(o_idle),
    .o_word(o_word), .o_word_valid(o_word_valid), .link(link)
  );

  sarc_link_assertions u_sarc_link_assertions (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_chain_sel(i_chain_sel),
    .convert_strobe(link.convert_strobe),
    .sck(link.sck), .output_enable_or_daisy_input(link.output_enable_or_daisy_input),
    .busy(link.busy), .sdo(link.sdo), .sdo_oe(link.sdo_oe)
  );

  // Core clock, 40 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  task automatic cmp(input string what, input logic [RES_BITS-1:0] exp,
                     input logic [RES_BITS-1:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One conversion: wait for the host, note the expected code, pulse start
  task automatic convert(input logic [RES_BITS-1:0] code);
    while (o_idle !== 1'b1) @(negedge i_core_clk);
    cmp("idle data line", 20'h0_0001, 20'(i_chain_sel ? link.sdo_oe : link.sdo_line));
    cmp("powered when idle", 20'h0_0000, 20'(o_powered));
    @(posedge i_core_clk);
    i_start <= 1'b1;
    i_analog_code <= code;
    exp_q.push_back(code);
    res_q.push_back(code);
    @(posedge i_core_clk);
    i_start <= 1'b0;
    @(negedge i_core_clk);
  endtask

  // Watcher: takes the oldest note whenever a result shows up
  always @(posedge i_core_clk) begin
    acq_d <= o_acquiring;
    busy_d <= link.busy;
    acq_cnt <= (link.busy && !busy_d) ? 16'h0000 : acq_cnt + 16'h0001;
    ign_seen <= ign_seen || o_start_ignored === 1'b1;
    // Only a rise during a conversion is timed; the one at init exit is not
    if (o_acquiring === 1'b1 && acq_d === 1'b0 && link.busy === 1'b1)
      cmp("acquire delay", 20'(ACQ_START_CYC), 20'(acq_cnt + 16'h0001));
    if (o_word_valid === 1'b1) cmp("read word", exp_q.pop_front(), o_word);
    if (o_conv_done === 1'b1) cmp("result", res_q.pop_front(), o_result);
    if (o_conv_done === 1'b1) cmp("start ignored", 20'h0_0000, 20'(ign_seen));
  end

  // Hang guard: a run past the ceiling counts as a mismatch
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    i_reset = 1'b1;
    i_start = 1'b0;
    i_supply_low = 1'b0;
    i_chain_sel = 1'b0;
    ign_seen = 1'b0;
    i_analog_code = '0;
    err_total = 0;
    checked = 0;
    cyc = 0;
    repeat (6) @(posedge i_core_clk);
    i_reset <= 1'b0;
    n = 0;
    while (o_ready !== 1'b1) begin
      @(negedge i_core_clk);
      n++;
    end
    cmp("ready after power-on", 20'h0_0001, 20'(n >= 40 && n <= 43));
    // Boundary codes, then random ones back to back
    foreach (EDGES[i]) convert(EDGES[i]);
    repeat (6) convert(20'($random(seed)));
    while (exp_q.size() != 0) @(negedge i_core_clk);
    // Supply drop with the host idle forces a fresh init; chain strap taken then
    @(posedge i_core_clk);
    i_supply_low <= 1'b1;
    i_chain_sel <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    i_supply_low <= 1'b0;
    @(negedge i_core_clk);
    cmp("ready after drop", 20'h0_0000, 20'(o_ready));
    n = 0;
    while (o_ready !== 1'b1) begin
      @(negedge i_core_clk);
      n++;
    end
    cmp("reinit length", 20'h0_0001, 20'(n >= 30 && n <= 48));
    // One conversion in chain mode: driver stays on; host reads the word only, no daisy bits
    convert(20'($random(seed)));
    while (exp_q.size() != 0) @(negedge i_core_clk);
    wrap_up();
  end
endmodule

// file: include/sarc_if.sv
// Link between the host controller and the converter device
interface sarc_if;
  logic convert_strobe;
  logic sck;
  logic output_enable_or_daisy_input;
  logic busy;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // Shared data line floats high when no device drives it
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (
    input  convert_strobe,
    input  sck,
    input  output_enable_or_daisy_input,
    output busy,
    output sdo,
    output sdo_oe
  );

  modport host (
    output convert_strobe,
    output sck,
    output output_enable_or_daisy_input,
    input  busy,
    input  sdo_line
  );
endinterface

// file: include/sarc_pkg.sv
// Shared constants and types for the converter sequencing and readout link
package sarc_pkg;

  // Word and counter widths
  localparam int RES_BITS = 20;
  localparam int CNT_W    = 16;
  localparam int PH_W     = 8;

  // Core clock period and documented times
  localparam int CORE_PERIOD_NS = 40;
  localparam int POR_WAIT_NS    = 200_000;
  localparam int CONV_MAX_NS    = 3000;
  localparam int ACQ_START_NS   = 675;

  // Least times round up, longest times round down
  localparam logic [CNT_W-1:0] POR_WAIT_CYC =
    CNT_W'((POR_WAIT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'(CONV_MAX_NS / CORE_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACQ_START_CYC =
    CNT_W'((ACQ_START_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);

  // Host serial clock half period in core cycles
  localparam int SCK_HALF_CYC = 3;

  // Device core sequencer states
  typedef enum logic [2:0] {
    DS_INIT  = 3'h1,
    DS_SLEEP = 3'h2,
    DS_CONV  = 3'h4
  } sarc_dev_state_t;

  // Host sequencer states
  typedef enum logic [4:0] {
    HS_WAIT  = 5'h01,
    HS_IDLE  = 5'h02,
    HS_CONV  = 5'h04,
    HS_SETUP = 5'h08,
    HS_SHIFT = 5'h10
  } sarc_host_state_t;

endpackage

// file: logic/sarc_device.sv
// Converter device end: conversion sequencing, power state and serial readout
//
// Operation
// - Reset at power-up and on supply drop
// - Host waits reinit period before converting; host waits it only after i_reset, not after a supply drop
// - Strobe rising edge powers up, starts conversion
// - Start requests ignored while converting
// - Busy high exactly while conversion runs
// - Host strobe edges only early or after completion
// - Acquisition starts fixed time after conversion start
// - Internal clock finishes conversion within bound
// - Auto power-down; old result stays readable
// - Host idles output and clock when down
// - Shift only with clock and output enabled; device shifts on any sck rising edge, even during init with enable high
// - Host reads after completion, fast clock
// - Data changes on rising clock edge
// - Normal mode: enable high floats data line
// - Normal mode: MSB valid at busy fall
// - Host enables one shared device at once
// - Enable low puts MSB on line at once
// - Chain mode: output always on, daisy input
// - Chain mode: upstream MSB out after twenty clocks
module sarc_device #(
  parameter logic [sarc_pkg::CNT_W-1:0] POR_WAIT = sarc_pkg::POR_WAIT_CYC
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_supply_low,
  input  wire logic                          i_chain_sel,
  input  wire logic [sarc_pkg::RES_BITS-1:0] i_analog_code,
  output logic                               o_powered,
  output logic                               o_acquiring,
  output logic                               o_ready,
  output logic [sarc_pkg::RES_BITS-1:0]      o_result,
  output logic                               o_conv_done,
  output logic                               o_start_ignored,
  sarc_if.dev                                link
);
  import sarc_pkg::*;

  // Core domain state, clocked by the internal conversion clock
  typedef struct packed {
    sarc_dev_state_t       st;
    logic                  strb_q;
    logic [CNT_W-1:0]      cnt;
    logic [RES_BITS-1:0]   code;
    logic [RES_BITS-1:0]   sar;
    logic [RES_BITS-1:0]   result;
    logic                  ld_tgl;
    logic                  busy;
    logic                  acq;
    logic                  pwr;
    logic                  chain;
    logic                  rdy;
    logic                  lrst;
    logic                  done;
    logic                  ign;
  } sarc_core_t;

  // Link domain state, clocked by the serial clock
  typedef struct packed {
    logic                  seen;
    logic [RES_BITS-1:0]   shreg;
  } sarc_link_t;

  localparam sarc_core_t CORE_RST = '{st: DS_INIT, lrst: 1'b1, default: '0};

  sarc_core_t core_ff;
  sarc_core_t nxt_core;
  sarc_link_t lnk_ff;
  sarc_link_t nxt_lnk;

  logic strb_s;
  logic supply_low_s;
  logic lrst_s;
  logic strb_rise;
  logic fresh;

  // One successive-approximation trial: keep the bit if it does not overshoot
  function automatic logic [RES_BITS-1:0] sar_step(
    input logic [RES_BITS-1:0] acc,
    input logic [RES_BITS-1:0] target,
    input logic [4:0]          k
  );
    logic [RES_BITS-1:0] trial;
    trial    = acc;
    trial[k] = 1'b1;
    return (trial <= target) ? trial : acc;
  endfunction

  // Strobe and supply pins cross into the core domain before any logic sees them
  sarc_sync2 u_sync_strb (
    .i_clk (i_core_clk),
    .i_d   (link.convert_strobe),
    .o_q   (strb_s)
  );

  sarc_sync2 u_sync_supply (
    .i_clk (i_core_clk),
    .i_d   (i_supply_low),
    .o_q   (supply_low_s)
  );

  // Link reset request crosses on the serial clock; host runs it during init
  sarc_sync2 u_sync_lrst (
    .i_clk (link.sck),
    .i_d   (core_ff.lrst),
    .o_q   (lrst_s)
  );

  assign strb_rise = strb_s & ~core_ff.strb_q;

  // Core sequencer: init, sleep and conversion
  always_comb begin
    nxt_core        = core_ff;
    nxt_core.strb_q = strb_s;
    nxt_core.done   = 1'b0;
    nxt_core.ign    = 1'b0;
    case (core_ff.st)
      DS_INIT: begin
        // Strap is caught by a clocked process after reset release
        nxt_core.chain = i_chain_sel;
        // Link reset covers only the first quarter of the wait, so its release
        // still reaches the serial domain while the host keeps the clock running
        nxt_core.lrst  = (core_ff.cnt < (POR_WAIT >> 2));
        nxt_core.cnt   = core_ff.cnt + 1'b1;
        if (core_ff.cnt == POR_WAIT - 1'b1) begin
          nxt_core.st   = DS_SLEEP;
          nxt_core.cnt  = '0;
          nxt_core.rdy  = 1'b1;
          nxt_core.acq  = 1'b1;
          nxt_core.lrst = 1'b0;
        end
      end
      DS_SLEEP: begin
        if (strb_rise) begin
          nxt_core.st   = DS_CONV;
          nxt_core.pwr  = 1'b1;
          nxt_core.busy = 1'b1;
          nxt_core.acq  = 1'b0;
          nxt_core.cnt  = '0;
          nxt_core.code = i_analog_code;
          nxt_core.sar  = '0;
        end
      end
      DS_CONV: begin
        // Further strobe edges are only flagged, never restart
        nxt_core.ign = strb_rise;
        nxt_core.cnt = core_ff.cnt + 1'b1;
        if (core_ff.cnt < CNT_W'(RES_BITS)) begin
          nxt_core.sar = sar_step(core_ff.sar, core_ff.code,
                                  5'(RES_BITS - 1) - core_ff.cnt[4:0]);
        end
        if (core_ff.cnt == ACQ_START_CYC - 1'b1) begin
          nxt_core.acq = 1'b1;
        end
        if (core_ff.cnt == CONV_CYC - 1'b1) begin
          nxt_core.st     = DS_SLEEP;
          nxt_core.busy   = 1'b0;
          nxt_core.pwr    = 1'b0;
          nxt_core.result = core_ff.sar;
          nxt_core.ld_tgl = ~core_ff.ld_tgl;
          nxt_core.done   = 1'b1;
        end
      end
      default: begin
        nxt_core = CORE_RST;
      end
    endcase
    // A supply dip restarts the whole init sequence
    if (supply_low_s) begin
      nxt_core        = CORE_RST;
      // Load toggle survives, so a link that saw no clock keeps no false load
      nxt_core.ld_tgl = core_ff.ld_tgl;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      core_ff <= CORE_RST;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // Result and load toggle are quasi-static in the link domain: they change
  // only at busy fall, and the host starts the clock only after seeing busy low.
  // A host that clocks during a conversion reads a mixed word.
  assign fresh = core_ff.ld_tgl ^ lnk_ff.seen;

  // Shift register loads the new result on the first rising edge after it
  always_comb begin
    nxt_lnk = lnk_ff;
    if (fresh) begin
      nxt_lnk.seen  = core_ff.ld_tgl;
      nxt_lnk.shreg = {core_ff.result[RES_BITS-2:0],
                       link.output_enable_or_daisy_input};
    end else begin
      nxt_lnk.shreg = {lnk_ff.shreg[RES_BITS-2:0],
                       link.output_enable_or_daisy_input};
    end
  end

  // Serial clock only runs when the host supplies it
  always_ff @(posedge link.sck) begin
    if (lrst_s) begin
      // Follow the quasi-static toggle so no stale load is pending after reset
      lnk_ff <= '{seen: core_ff.ld_tgl, shreg: '0};
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // Before the first edge the MSB comes straight from the stored result
  assign link.sdo = fresh ? core_ff.result[RES_BITS-1]
                          : lnk_ff.shreg[RES_BITS-1];

  // Chain mode keeps the driver on; normal mode follows the enable pin
  assign link.sdo_oe = core_ff.chain
                     | ~link.output_enable_or_daisy_input;

  assign link.busy       = core_ff.busy;
  assign o_powered       = core_ff.pwr;
  assign o_acquiring     = core_ff.acq;
  assign o_ready         = core_ff.rdy;
  assign o_result        = core_ff.result;
  assign o_conv_done     = core_ff.done;
  assign o_start_ignored = core_ff.ign;

endmodule

// file: logic/sarc_host.sv
// Host controller end: strobes conversions and clocks results out
module sarc_host #(
  parameter logic [sarc_pkg::CNT_W-1:0] POR_WAIT   = sarc_pkg::POR_WAIT_CYC,
  parameter int                         FRAME_BITS = sarc_pkg::RES_BITS,
  parameter int                         SCK_HALF   = sarc_pkg::SCK_HALF_CYC
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_start,
  output logic                       o_idle,
  output logic [FRAME_BITS-1:0]      o_word,
  output logic                       o_word_valid,
  sarc_if.host                       link
);
  import sarc_pkg::*;

  typedef struct packed {
    sarc_host_state_t      st;
    logic [CNT_W-1:0]      cnt;
    logic [PH_W-1:0]       ph;
    logic [PH_W-1:0]       nbit;
    logic [FRAME_BITS-1:0] word;
    logic                  valid;
    logic                  strobe;
    logic                  sck;
    logic                  oe_n;
    logic                  seen_busy;
    logic                  idle;
  } sarc_hctl_t;

  localparam sarc_hctl_t HOST_RST = '{st: HS_WAIT, oe_n: 1'b1, default: '0};
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(SCK_HALF);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * SCK_HALF - 1);

  sarc_hctl_t h_ff;
  sarc_hctl_t nxt_h;
  logic       busy_s;
  logic       sdo_s;

  sarc_sync2 u_sync_busy (
    .i_clk (i_core_clk),
    .i_d   (link.busy),
    .o_q   (busy_s)
  );

  sarc_sync2 u_sync_sdo (
    .i_clk (i_core_clk),
    .i_d   (link.sdo_line),
    .o_q   (sdo_s)
  );

  // Sequencer; the serial clock is this core clock divided by 2*SCK_HALF
  always_comb begin
    nxt_h       = h_ff;
    nxt_h.valid = 1'b0;
    nxt_h.ph    = (h_ff.ph == PH_LAST) ? '0 : h_ff.ph + 1'b1;
    case (h_ff.st)
      HS_WAIT: begin
        // Clock runs while waiting so the device link logic sees its reset
        nxt_h.cnt = h_ff.cnt + 1'b1;
        if (h_ff.ph == PH_LAST || h_ff.ph == PH_HALF - 1'b1) begin
          nxt_h.sck = ~h_ff.sck;
        end
        if (h_ff.cnt == POR_WAIT - 1'b1) begin
          nxt_h.st   = HS_IDLE;
          nxt_h.sck  = 1'b0;
          nxt_h.idle = 1'b1;
        end
      end
      HS_IDLE: begin
        if (i_start) begin
          nxt_h.st        = HS_CONV;
          nxt_h.strobe    = 1'b1;
          nxt_h.idle      = 1'b0;
          nxt_h.seen_busy = 1'b0;
        end
      end
      HS_CONV: begin
        // Strobe falls only after the conversion is over
        if (busy_s) begin
          nxt_h.seen_busy = 1'b1;
        end
        if (h_ff.seen_busy && !busy_s) begin
          nxt_h.st     = HS_SETUP;
          nxt_h.strobe = 1'b0;
          nxt_h.oe_n   = 1'b0;
          nxt_h.ph     = '0;
        end
      end
      HS_SETUP: begin
        // Let the MSB reach the synchroniser before the first edge
        if (h_ff.ph == PH_LAST) begin
          nxt_h.st   = HS_SHIFT;
          nxt_h.nbit = '0;
        end
      end
      HS_SHIFT: begin
        if (h_ff.ph == '0) begin
          nxt_h.word = {h_ff.word[FRAME_BITS-2:0], sdo_s};
          nxt_h.nbit = h_ff.nbit + 1'b1;
          if (h_ff.nbit == PH_W'(FRAME_BITS - 1)) begin
            nxt_h.st    = HS_IDLE;
            nxt_h.oe_n  = 1'b1;
            nxt_h.valid = 1'b1;
            nxt_h.idle  = 1'b1;
          end else begin
            nxt_h.sck = 1'b1;
          end
        end
        if (h_ff.ph == PH_HALF) begin
          nxt_h.sck = 1'b0;
        end
      end
      default: begin
        nxt_h = HOST_RST;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      h_ff <= HOST_RST;
    end else begin
      h_ff <= nxt_h;
    end
  end

  assign link.convert_strobe               = h_ff.strobe;
  assign link.sck                          = h_ff.sck;
  assign link.output_enable_or_daisy_input = h_ff.oe_n;
  assign o_idle                            = h_ff.idle;
  assign o_word                            = h_ff.word;
  assign o_word_valid                      = h_ff.valid;

endmodule

// file: logic/sarc_sync2.sv
// Two flip-flop level synchroniser
module sarc_sync2 (
  input  wire logic i_clk,
  input  wire logic i_d,
  output logic      o_q
);
  import sarc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } sarc_sync_t;

  sarc_sync_t sync_ff;
  sarc_sync_t nxt_sync;

  // First stage feeds only the second stage
  always_comb begin
    nxt_sync.s1 = i_d;
    nxt_sync.s2 = sync_ff.s1;
  end

  always_ff @(posedge i_clk) begin
    sync_ff <= nxt_sync;
  end

  assign o_q = sync_ff.s2;
endmodule
